// ==== verilog/synth_cfg_defines.svh ====
// Field positions, latch selects and timing counts of the serial configuration latches
`ifndef SYNTH_CFG_DEFINES_SVH
`define SYNTH_CFG_DEFINES_SVH
`define WORD_BITS 24
`define SEL_CONTROL 2'h0
`define SEL_REFERENCE 2'h1
`define SEL_FEEDBACK 2'h2
`define SEL_TEST 2'h3
`define CTL_PRESCALER_HI 23
`define CTL_PRESCALER_LO 22
`define CTL_PD_QUALIFIER 21
`define CTL_PD_REQUEST 20
`define CTL_PUMP_TWO_HI 19
`define CTL_PUMP_TWO_LO 17
`define CTL_PUMP_ONE_HI 16
`define CTL_PUMP_ONE_LO 14
`define CTL_LEVEL_HI 13
`define CTL_LEVEL_LO 12
`define CTL_MUTE 11
`define CTL_GAIN 10
`define CTL_TRISTATE 9
`define CTL_POLARITY 8
`define CTL_MUX_HI 7
`define CTL_MUX_LO 5
`define CTL_CLEAR 4
`define CTL_CORE_HI 3
`define CTL_CORE_LO 2
`define FB_HALVED_INPUT 23
`define FB_HALVING 22
`define FB_GAIN 21
`define FB_B_HI 20
`define FB_B_LO 8
`define FB_RESERVED 7
`define FB_A_HI 6
`define FB_A_LO 2
`define REF_RESERVED_HI 23
`define REF_RESERVED_LO 22
`define REF_BAND_HI 21
`define REF_BAND_LO 20
`define REF_TEST 19
`define REF_PRECISION 18
`define REF_ABP_HI 17
`define REF_ABP_LO 16
`define REF_COUNT_HI 15
`define REF_COUNT_LO 2
`define SYNC_PD_EDGES 2'h2
`define CTL_RESET 24'h000000
`define FB_RESET 24'h000000
`define REF_RESET 24'h000000
`endif

// ==== verilog/synth_cfg_pkg.sv ====
// Types shared by the serial configuration latches
`default_nettype none
package synth_cfg_pkg;
  typedef struct packed {
    logic [1:0] prescaler;
    logic [2:0] pump_setting_two;
    logic [2:0] pump_setting_one;
    logic [1:0] out_level;
    logic mute_until_locked;
    logic pump_tristate;
    logic detector_polarity;
    logic [2:0] mux_select;
    logic counter_clear;
    logic [1:0] core_current;
  } control_fields_t;
  typedef struct packed {
    logic halved_prescaler_input;
    logic output_halving;
    logic [12:0] b_count;
    logic [4:0] a_count;
  } feedback_fields_t;
  typedef struct packed {
    logic [1:0] band_clock_div;
    logic factory_test_flag;
    logic lock_precision;
    logic [1:0] antibacklash_width;
    logic [13:0] ref_count;
  } reference_fields_t;
  typedef enum logic [2:0] {
    PWR_OFF = 3'h1,
    PWR_ON = 3'h2,
    PWR_SYNC_WAIT = 3'h4
  } power_state_t;
endpackage : synth_cfg_pkg
`default_nettype wire

// ==== verilog/edge_sync.sv ====
// Two-flop synchroniser with rising-edge detect for one pin
`default_nettype none
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~last_r;
endmodule // edge_sync
`default_nettype wire

// ==== verilog/synth_cfg_latches.sv ====
// Serial latch bank and power-down control of the integer-N synthesizer
`default_nettype none
`include "synth_cfg_defines.svh"
module synth_cfg_latches #(
  parameter int WORD_W = `WORD_BITS
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH_STROBE,
  input wire logic CHIP_ENABLE,
  input wire logic REF_DIV_OUT,
  input wire logic LOOP_LOCKED,
  output synth_cfg_pkg::control_fields_t CONTROL_FIELDS,
  output synth_cfg_pkg::feedback_fields_t FEEDBACK_FIELDS,
  output synth_cfg_pkg::reference_fields_t REFERENCE_FIELDS,
  output logic PUMP_GAIN,
  output logic POWERED_DOWN,
  output logic COUNTERS_LOAD,
  output logic PUMP_TRISTATE,
  output logic LOCK_DETECT_CLEAR,
  output logic RF_OUT_ENABLE,
  output logic REF_BUFFER_ENABLE,
  output logic BAND_SELECT_START
);
  logic sclk_rise;
  logic sdata;
  logic strobe_rise;
  logic ce_level;
  logic ref_rise;
  logic lock_level;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] ctl_r;
  logic [WORD_W-1:0] fb_r;
  logic [WORD_W-1:0] ref_r;
  logic gain_r;
  logic [1:0] edge_cnt_r;
  synth_cfg_pkg::power_state_t state_r;
  synth_cfg_pkg::power_state_t state_nxt;
  logic down_nxt;
  logic [1:0] sel;
  logic wr_ctl;
  logic wr_fb;
  logic wr_ref;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; serial clock is sampled, not used as a clock
  edge_sync u_sclk (.clk(CLOCK), .rst(SYS_RST), .pin(SER_CLK), .level(), .rise(sclk_rise));
  edge_sync u_sdat (.clk(CLOCK), .rst(SYS_RST), .pin(SER_DATA), .level(sdata), .rise());
  edge_sync u_le (.clk(CLOCK), .rst(SYS_RST), .pin(LATCH_STROBE), .level(), .rise(strobe_rise));
  edge_sync u_ce (.clk(CLOCK), .rst(SYS_RST), .pin(CHIP_ENABLE), .level(ce_level), .rise());
  edge_sync u_ref (.clk(CLOCK), .rst(SYS_RST), .pin(REF_DIV_OUT), .level(), .rise(ref_rise));
  edge_sync u_lock (.clk(CLOCK), .rst(SYS_RST), .pin(LOOP_LOCKED), .level(lock_level), .rise());

  ////////////////////////////////////////////////////////////////////////////
  // Shift register runs in every power state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      shift_r <= '0;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], sdata};
    end
  end

  assign sel = shift_r[1:0];
  assign wr_ctl = strobe_rise && (sel == `SEL_CONTROL);
  assign wr_ref = strobe_rise && (sel == `SEL_REFERENCE);
  assign wr_fb = strobe_rise && (sel == `SEL_FEEDBACK);
  // Test-latch words are dropped: factory use only

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctl_r <= `CTL_RESET;
      fb_r <= `FB_RESET;
      ref_r <= `REF_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_r <= shift_r;
      end
      if (wr_fb) begin
        fb_r <= shift_r;
      end
      if (wr_ref) begin
        ref_r <= shift_r;
      end
    end
  end

  // Last writer through either latch owns the gain bit
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      gain_r <= 1'b0;
    end else if (wr_ctl) begin
      gain_r <= shift_r[`CTL_GAIN];
    end else if (wr_fb) begin
      gain_r <= shift_r[`FB_GAIN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state: off until a control write with the power-down bit clear, async/sync power-down
  always_comb begin
    state_nxt = state_r;
    if (wr_ctl) begin
      if (!shift_r[`CTL_PD_REQUEST]) begin
        state_nxt = synth_cfg_pkg::PWR_ON;
      end else if (!shift_r[`CTL_PD_QUALIFIER]) begin
        state_nxt = synth_cfg_pkg::PWR_OFF;
        // A sync request while already off leaves the device off
      end else if (state_r != synth_cfg_pkg::PWR_OFF) begin
        state_nxt = synth_cfg_pkg::PWR_SYNC_WAIT;
      end
    end else if (state_r == synth_cfg_pkg::PWR_SYNC_WAIT && ref_rise && edge_cnt_r == `SYNC_PD_EDGES - 2'h1) begin
      state_nxt = synth_cfg_pkg::PWR_OFF;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_r <= synth_cfg_pkg::PWR_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reference edges counted only after the strobe that armed the wait
  // A fresh control strobe restarts the count from its own edge
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      edge_cnt_r <= 2'h0;
    end else if (wr_ctl || state_nxt != synth_cfg_pkg::PWR_SYNC_WAIT || state_r != synth_cfg_pkg::PWR_SYNC_WAIT) begin
      edge_cnt_r <= 2'h0;
    end else if (ref_rise) begin
      edge_cnt_r <= edge_cnt_r + 2'h1;
    end
  end

  assign down_nxt = (state_nxt == synth_cfg_pkg::PWR_OFF) || !ce_level;

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Power-down effects follow the next state, so they land with POWERED_DOWN
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      POWERED_DOWN <= 1'b1;
      COUNTERS_LOAD <= 1'b1;
      PUMP_TRISTATE <= 1'b1;
      LOCK_DETECT_CLEAR <= 1'b1;
      RF_OUT_ENABLE <= 1'b0;
      REF_BUFFER_ENABLE <= 1'b0;
    end else begin
      POWERED_DOWN <= down_nxt;
      COUNTERS_LOAD <= down_nxt || ctl_r[`CTL_CLEAR];
      PUMP_TRISTATE <= down_nxt || ctl_r[`CTL_TRISTATE];
      LOCK_DETECT_CLEAR <= down_nxt;
      RF_OUT_ENABLE <= !down_nxt && (!ctl_r[`CTL_MUTE] || lock_level);
      REF_BUFFER_ENABLE <= !down_nxt;
    end
  end

  // Band select on a divider write while up; reuse band otherwise
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      BAND_SELECT_START <= 1'b0;
    end else begin
      BAND_SELECT_START <= wr_fb && !down_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode; latch contents survive power-down, the load outputs hold counters
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      CONTROL_FIELDS <= '0;
    end else begin
      CONTROL_FIELDS.prescaler <= ctl_r[`CTL_PRESCALER_HI:`CTL_PRESCALER_LO];
      CONTROL_FIELDS.pump_setting_two <= ctl_r[`CTL_PUMP_TWO_HI:`CTL_PUMP_TWO_LO];
      CONTROL_FIELDS.pump_setting_one <= ctl_r[`CTL_PUMP_ONE_HI:`CTL_PUMP_ONE_LO];
      CONTROL_FIELDS.out_level <= ctl_r[`CTL_LEVEL_HI:`CTL_LEVEL_LO];
      CONTROL_FIELDS.mute_until_locked <= ctl_r[`CTL_MUTE];
      CONTROL_FIELDS.pump_tristate <= ctl_r[`CTL_TRISTATE];
      CONTROL_FIELDS.detector_polarity <= ctl_r[`CTL_POLARITY];
      CONTROL_FIELDS.mux_select <= ctl_r[`CTL_MUX_HI:`CTL_MUX_LO];
      CONTROL_FIELDS.counter_clear <= ctl_r[`CTL_CLEAR];
      CONTROL_FIELDS.core_current <= ctl_r[`CTL_CORE_HI:`CTL_CORE_LO];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      FEEDBACK_FIELDS <= '0;
    end else begin
      FEEDBACK_FIELDS.halved_prescaler_input <= fb_r[`FB_HALVED_INPUT];
      FEEDBACK_FIELDS.output_halving <= fb_r[`FB_HALVING];
      FEEDBACK_FIELDS.b_count <= fb_r[`FB_B_HI:`FB_B_LO];
      FEEDBACK_FIELDS.a_count <= fb_r[`FB_A_HI:`FB_A_LO];
    end
  end

  // Reserved bits 23..22 are not passed on
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      REFERENCE_FIELDS <= '0;
    end else begin
      REFERENCE_FIELDS.band_clock_div <= ref_r[`REF_BAND_HI:`REF_BAND_LO];
      REFERENCE_FIELDS.factory_test_flag <= ref_r[`REF_TEST];
      REFERENCE_FIELDS.lock_precision <= ref_r[`REF_PRECISION];
      REFERENCE_FIELDS.antibacklash_width <= ref_r[`REF_ABP_HI:`REF_ABP_LO];
      REFERENCE_FIELDS.ref_count <= ref_r[`REF_COUNT_HI:`REF_COUNT_LO];
    end
  end

  // Gain lands in the same cycle as the decoded fields, one cycle after the latch
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PUMP_GAIN <= 1'b0;
    end else begin
      PUMP_GAIN <= gain_r;
    end
  end
endmodule // synth_cfg_latches
`default_nettype wire

// ==== sim/serial_ctrl_model.sv ====
// Controller model driving the three-wire programming port
`default_nettype none
module serial_ctrl_model (
  output logic ser_clk,
  output logic ser_data,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    strobe = 1'b0;
  end
  // Entered at a falling CLOCK edge; 400 ns halves give the 800 ns link period
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #400 ser_clk = 1'b1;
      #400 ser_clk = 1'b0;
    end
    strobe = 1'b1;
    #400 strobe = 1'b0;
    // A released data line must not pass for a held bit
    ser_data = ~w[0];
    #400;
  endtask
endmodule // serial_ctrl_model
`default_nettype wire

// ==== sim/synth_cfg_latches_monitor.sv ====
// Port checks of the serial configuration latches
`default_nettype none
module synth_cfg_latches_monitor (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CHIP_ENABLE,
  input wire logic LOOP_LOCKED,
  input wire synth_cfg_pkg::control_fields_t CONTROL_FIELDS,
  input wire logic POWERED_DOWN,
  input wire logic COUNTERS_LOAD,
  input wire logic PUMP_TRISTATE,
  input wire logic LOCK_DETECT_CLEAR,
  input wire logic RF_OUT_ENABLE,
  input wire logic REF_BUFFER_ENABLE,
  input wire logic BAND_SELECT_START
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  ce_down_a: assert property (!CHIP_ENABLE [*4] |-> POWERED_DOWN)
    else $error("enable low left device up");
  down_loads_a: assert property (POWERED_DOWN |-> COUNTERS_LOAD && PUMP_TRISTATE && LOCK_DETECT_CLEAR)
    else $error("power-down left counters or pump live");
  down_mutes_a: assert property (POWERED_DOWN |-> !RF_OUT_ENABLE && !REF_BUFFER_ENABLE)
    else $error("power-down left outputs on");
  buffer_up_a: assert property (!POWERED_DOWN |-> REF_BUFFER_ENABLE)
    else $error("buffer off while up");
  clear_load_a: assert property (CONTROL_FIELDS.counter_clear |-> COUNTERS_LOAD)
    else $error("clear bit ignored");
  tristate_bit_a: assert property (CONTROL_FIELDS.pump_tristate |-> PUMP_TRISTATE)
    else $error("tristate ignored");
  mute_hold_a: assert property ((CONTROL_FIELDS.mute_until_locked && !LOOP_LOCKED) [*4] |-> !RF_OUT_ENABLE)
    else $error("output on before lock");
  unmuted_up_a: assert property ((!CONTROL_FIELDS.mute_until_locked && !POWERED_DOWN) [*2] |-> RF_OUT_ENABLE)
    else $error("output off while unmuted");
  band_pulse_a: assert property (BAND_SELECT_START |-> !POWERED_DOWN ##1 !BAND_SELECT_START)
    else $error("band start bad");
endmodule // synth_cfg_latches_monitor
bind synth_cfg_latches synth_cfg_latches_monitor synth_cfg_latches_monitor_inst (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .CHIP_ENABLE(CHIP_ENABLE), .LOOP_LOCKED(LOOP_LOCKED), .CONTROL_FIELDS(CONTROL_FIELDS),
  .POWERED_DOWN(POWERED_DOWN), .COUNTERS_LOAD(COUNTERS_LOAD), .PUMP_TRISTATE(PUMP_TRISTATE),
  .LOCK_DETECT_CLEAR(LOCK_DETECT_CLEAR), .RF_OUT_ENABLE(RF_OUT_ENABLE), .REF_BUFFER_ENABLE(REF_BUFFER_ENABLE),
  .BAND_SELECT_START(BAND_SELECT_START));
`default_nettype wire

// ==== sim/synth_cfg_latches_tb_top.sv ====
// Self-checking bench of the serial configuration latches
`default_nettype none
module synth_cfg_latches_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic refdiv = 1'b0;
  logic locked = 1'b0;
  logic sclk, sdata, strobe, gain, down, rf_en, band;
  synth_cfg_pkg::control_fields_t ctl_f;
  synth_cfg_pkg::feedback_fields_t fb_f;
  synth_cfg_pkg::reference_fields_t ref_f;
  int mismatches = 0, tests_run = 0, cyc = 0, band_cnt = 0, exp_band = 0;
  int m_ctl = 0, m_fb = 0, m_ref = 0, m_gain = 0, m_down = 1;
  int q[$];
  always #50 clk = ~clk;
  serial_ctrl_model serial_ctrl_model_inst (.ser_clk(sclk), .ser_data(sdata), .strobe(strobe));
  synth_cfg_latches synth_cfg_latches_inst (.CLOCK(clk), .SYS_RST(rst), .SER_CLK(sclk), .SER_DATA(sdata),
    .LATCH_STROBE(strobe), .CHIP_ENABLE(ce), .REF_DIV_OUT(refdiv), .LOOP_LOCKED(locked), .CONTROL_FIELDS(ctl_f),
    .FEEDBACK_FIELDS(fb_f), .REFERENCE_FIELDS(ref_f), .PUMP_GAIN(gain), .POWERED_DOWN(down), .COUNTERS_LOAD(),
    .PUMP_TRISTATE(), .LOCK_DETECT_CLEAR(), .RF_OUT_ENABLE(rf_en), .REF_BUFFER_ENABLE(), .BAND_SELECT_START(band));
  always @(posedge clk) begin
    if (band === 1'b1) band_cnt++;
    cyc++;
    // Whole run needs about 2350 cycles
    if (cyc == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_all();
    chk("control", 24'({m_ctl[23:22], m_ctl[19:11], m_ctl[9:2]}), 24'(ctl_f));
    chk("feedback", 24'({m_fb[23:22], m_fb[20:8], m_fb[6:2]}), 24'(fb_f));
    chk("reference", 24'(m_ref[21:2]), 24'(ref_f));
    chk("gain", 24'(m_gain), 24'(gain));
    chk("band", 24'(exp_band), 24'(band_cnt));
    chk("down", 24'(m_down), 24'(down));
  endtask
  task automatic wr(input int w);
    serial_ctrl_model_inst.send(w[23:0]);
    case (w & 3)
      0: begin
        m_ctl = w;
        m_gain = w[10];
        if (!w[20]) m_down = 0;
        else if (!w[21]) m_down = 1;
      end
      1: m_ref = w;
      2: begin
        m_fb = w;
        m_gain = w[21];
        if (m_down == 0) exp_band++;
      end
      default: ;
    endcase
    repeat (4) @(negedge clk);
  endtask
  task automatic pulse_ref();
    refdiv = 1'b1;
    repeat (4) @(negedge clk);
    refdiv = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'h96980604));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_all();
    // Reference, control, feedback order; settle gap shortened, the block does not time it
    q = {($urandom & 24'h3FFFFC) | 1, $urandom & 24'hCFF7FC, ($urandom & 24'hFFFF7C) | 2};
    foreach (q[i]) begin
      wr(q[i]);
      chk_all();
      repeat (20) @(negedge clk);
    end
    wr(($urandom & 24'hFFFFFC) | 3);
    chk_all();
    wr(m_ctl ^ 24'h000400);
    chk_all();
    $display("test program done");
    wr(m_ctl | 24'h100000);
    chk_all();
    // Divider word rewritten unchanged while down
    wr(m_fb);
    chk_all();
    wr(m_ctl & 24'hCFFFFF);
    chk_all();
    $display("test async down done");
    wr(m_ctl | 24'h300000);
    chk_all();
    pulse_ref();
    chk_all();
    pulse_ref();
    m_down = 1;
    chk_all();
    wr(m_ctl & 24'hCFFFFF);
    chk_all();
    $display("test sync down done");
    ce = 1'b0;
    repeat (5) @(negedge clk);
    m_down = 1;
    chk_all();
    ce = 1'b1;
    repeat (5) @(negedge clk);
    m_down = 0;
    chk_all();
    $display("test enable pin done");
    wr(m_ctl | 24'h000800);
    chk("muted", 24'h0, 24'(rf_en));
    locked = 1'b1;
    repeat (5) @(negedge clk);
    chk("unmuted", 24'h1, 24'(rf_en));
    $display("test mute done");
    print_verdict();
  end
endmodule // synth_cfg_latches_tb_top
`default_nettype wire
